// *** shared/cdt_pkg.sv ***
// Constants and types for the capture DMA event threshold block.
// Assumes a 32-bit AXI4-Lite register bus and one clock domain.
package cdt_pkg;
    // ==========================================
    // Register map
    localparam logic [3:0] OFS_THRESHOLD = 4'h0;
    localparam logic [3:0] OFS_EVENT_COUNT = 4'h4;
    localparam logic [3:0] OFS_CONTROL = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    localparam int ADDR_W = 4;
    // ==========================================
    // Field layout
    localparam int THR_W = 10;
    localparam int THR1_LSB = 0;
    localparam int THR2_LSB = 16;
    localparam int EVC_W = 12;
    localparam int EVC1_LSB = 0;
    localparam int EVC2_LSB = 16;
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_SIZE_LSB = 2;
    localparam int CTL_F2EN_BIT = 8;
    localparam int STS_ACTIVE_BIT = 16;
    localparam int STS_LUMA_BLK_BIT = 17;
    localparam int STS_CHROMA_BLK_BIT = 18;
    localparam logic [31:0] THRESHOLD_RESET = 32'h0000_0000;
    localparam logic [31:0] EVENT_COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // Modes
    typedef enum logic [1:0] {MODE_COMPONENT, MODE_RAW, MODE_TSI} cdt_mode_t;
    typedef enum logic [2:0] {SZ_8, SZ_10, SZ_DENSE10, SZ_16, SZ_20} cdt_size_t;
    localparam logic [3:0] SPD_BYTE = 4'h8;
    localparam logic [3:0] SPD_HALF = 4'h4;
    localparam logic [3:0] SPD_DENSE = 4'h6;
    localparam logic [3:0] SPD_WORD = 4'h2;

    // Values per double word of FIFO, by mode and sample size
    function automatic logic [3:0] samples_per_dword(input cdt_mode_t mode, input cdt_size_t size);
        logic [3:0] spd;
        spd = SPD_HALF;
        if (mode == MODE_TSI)
            spd = SPD_BYTE;
        else if (size == SZ_8)
            spd = SPD_BYTE;
        else if (size == SZ_DENSE10)
            spd = SPD_DENSE;
        else if (size == SZ_20 && mode == MODE_RAW)
            spd = SPD_WORD;
        return spd;
    endfunction
endpackage

// *** rtl/cdt_fifo_meter.sv ***
// Fill meter of one capture FIFO: counts written values into double words
// and raises one event per threshold, then waits for the first DMA read.
// Assumes write and read strobes come from logic on aclk.
module cdt_fifo_meter #(
    parameter int THR_W = 10
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic wr_value,
    input wire logic dma_read,
    input wire logic [3:0] spd,
    input wire logic [THR_W-1:0] threshold,
    output logic dma_event,
    output logic blocked
);
    typedef struct packed {
        logic [3:0] frac;
        logic [THR_W:0] dwords;
        logic armed;
        logic event_out;
    } cdt_meter_t;

    cdt_meter_t s_q;
    cdt_meter_t s_d;

    // ==========================================
    // Next state
    always_comb
    begin
        s_d = s_q;
        s_d.event_out = 1'b0;
        if (clear)
        begin
            s_d = '0;
            s_d.armed = 1'b1;
        end
        else
        begin
            // Count what enters the FIFO, whatever filter fed it
            if (wr_value)
            begin
                if (s_q.frac + 4'h1 >= spd)
                begin
                    s_d.frac = 4'h0;
                    if (s_q.dwords != '1)
                        s_d.dwords = s_q.dwords + 1'b1;
                end
                else
                    s_d.frac = s_q.frac + 4'h1;
            end
            if (dma_read)
                s_d.armed = 1'b1;
            // A zero threshold never raises an event
            if (s_d.armed && threshold != '0 && s_d.dwords >= {1'b0, threshold})
            begin
                s_d.event_out = 1'b1;
                s_d.dwords = s_d.dwords - {1'b0, threshold};
                s_d.armed = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '{frac: 4'h0, dwords: '0, armed: 1'b1, event_out: 1'b0};
        else
            s_q <= s_d;
    end

    assign dma_event = s_q.event_out;
    assign blocked = !s_q.armed;
endmodule

// *** rtl/cdt_capture_dma.sv ***
// Capture DMA event generator for one video capture channel.
// Assumes strobes from the capture path and DMA on aclk, and an
// AXI4-Lite master that keeps one write and one read in flight.
//
// Function
// - After an event, block further events until the DMA first reads that FIFO.
// - Component modes: a pixel pair gives two luma, one blue, one red value.
// - Component double word is 8, 4 or 6 pixels by data size.
// - Chroma FIFOs use half the luma threshold; software keeps it valid halved.
// - Raw double word is 8, 4, 6 or 2 samples by sample size.
// - Transport stream double word is eight one-byte samples.
// - Field-2 threshold used in field 2 only when enabled, else field-1.
// - Count data as written into the FIFO, after any filter.
// - Threshold register: field-2 count bits 25-16, field-1 bits 9-0, reset 0.
// - Reserved threshold and event count bits read zero, ignore writes.
// - Event count register: field-2 sets bits 27-16, field-1 bits 11-0.
// - Event counter picks the threshold for events and outgoing data counter.
// - After the programmed event sets, switch to the other field threshold.
// - Raw and stream modes use only field-1 threshold; ignore counts.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
module cdt_capture_dma (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [cdt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cdt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic channel_reset,
    input wire logic field_start,
    input wire logic field_is_two,
    input wire logic luma_wr_value,
    input wire logic blue_wr_value,
    input wire logic red_wr_value,
    input wire logic luma_dma_read,
    input wire logic blue_dma_read,
    input wire logic red_dma_read,
    output logic luma_dma_event,
    output logic blue_chroma_dma_event,
    output logic red_chroma_dma_event,
    output logic [cdt_pkg::THR_W-1:0] active_threshold,
    output logic active_field_two
);
    // ==========================================
    // State
    typedef struct packed {
        logic [cdt_pkg::THR_W-1:0] field1_dword_threshold;
        logic [cdt_pkg::THR_W-1:0] field2_dword_threshold;
        logic [cdt_pkg::EVC_W-1:0] field1_event_sets;
        logic [cdt_pkg::EVC_W-1:0] field2_event_sets;
        logic [1:0] mode;
        logic [2:0] size;
        logic field2_threshold_enable;
        logic [cdt_pkg::EVC_W-1:0] sets_done;
        logic use_field2;
        logic [cdt_pkg::THR_W-1:0] thr_out;
        logic [cdt_pkg::ADDR_W-1:0] awaddr;
        logic aw_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_have;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cdt_state_t;

    cdt_state_t s_q;
    cdt_state_t s_d;

    cdt_pkg::cdt_mode_t mode;
    cdt_pkg::cdt_size_t size;
    logic component;
    logic [3:0] spd;
    logic [cdt_pkg::THR_W-1:0] luma_thr;
    logic [cdt_pkg::THR_W-1:0] chroma_thr;
    logic meter_clear;
    logic luma_evt;
    logic blue_evt;
    logic red_evt;
    logic luma_blk;
    logic blue_blk;
    logic red_blk;

    // ==========================================
    // Mode decode and threshold selection
    assign mode = cdt_pkg::cdt_mode_t'(s_q.mode);
    assign size = cdt_pkg::cdt_size_t'(s_q.size);
    assign component = (mode == cdt_pkg::MODE_COMPONENT);
    assign spd = cdt_pkg::samples_per_dword(mode, size);
    // Field-2 threshold only in component modes
    assign luma_thr = (component && s_q.use_field2) ? s_q.field2_dword_threshold : s_q.field1_dword_threshold;
    // Chroma halves the luma figure; odd thresholds lose the low bit
    assign chroma_thr = component ? (luma_thr >> 1) : '0;
    assign meter_clear = channel_reset || field_start;

    // ==========================================
    // FIFO meters
    // Each value strobe is one FIFO entry: luma gets two per pixel pair,
    // each chroma FIFO one
    cdt_fifo_meter #(
        .THR_W(cdt_pkg::THR_W)
    ) u_luma (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(meter_clear),
        .wr_value(luma_wr_value),
        .dma_read(luma_dma_read),
        .spd(spd),
        .threshold(luma_thr),
        .dma_event(luma_evt),
        .blocked(luma_blk)
    );

    cdt_fifo_meter #(
        .THR_W(cdt_pkg::THR_W)
    ) u_blue (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(meter_clear),
        .wr_value(blue_wr_value && component),
        .dma_read(blue_dma_read),
        .spd(spd),
        .threshold(chroma_thr),
        .dma_event(blue_evt),
        .blocked(blue_blk)
    );

    cdt_fifo_meter #(
        .THR_W(cdt_pkg::THR_W)
    ) u_red (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(meter_clear),
        .wr_value(red_wr_value && component),
        .dma_read(red_dma_read),
        .spd(spd),
        .threshold(chroma_thr),
        .dma_event(red_evt),
        .blocked(red_blk)
    );

    // ==========================================
    // Register read mux
    function automatic logic [31:0] read_word(input cdt_state_t s, input logic [cdt_pkg::ADDR_W-1:0] a,
                                              input logic [2:0] blk);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            cdt_pkg::OFS_THRESHOLD:
            begin
                // Upper bits stay zero
                v[cdt_pkg::THR2_LSB +: cdt_pkg::THR_W] = s.field2_dword_threshold;
                v[cdt_pkg::THR1_LSB +: cdt_pkg::THR_W] = s.field1_dword_threshold;
            end
            cdt_pkg::OFS_EVENT_COUNT:
            begin
                v[cdt_pkg::EVC2_LSB +: cdt_pkg::EVC_W] = s.field2_event_sets;
                v[cdt_pkg::EVC1_LSB +: cdt_pkg::EVC_W] = s.field1_event_sets;
            end
            cdt_pkg::OFS_CONTROL:
            begin
                v[cdt_pkg::CTL_MODE_LSB +: 2] = s.mode;
                v[cdt_pkg::CTL_SIZE_LSB +: 3] = s.size;
                v[cdt_pkg::CTL_F2EN_BIT] = s.field2_threshold_enable;
            end
            cdt_pkg::OFS_STATUS:
            begin
                v[cdt_pkg::EVC1_LSB +: cdt_pkg::EVC_W] = s.sets_done;
                v[cdt_pkg::STS_ACTIVE_BIT] = s.use_field2;
                v[cdt_pkg::STS_LUMA_BLK_BIT] = blk[0];
                v[cdt_pkg::STS_CHROMA_BLK_BIT] = blk[1] || blk[2];
            end
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [cdt_pkg::ADDR_W-1:0] a);
        return a == cdt_pkg::OFS_THRESHOLD || a == cdt_pkg::OFS_EVENT_COUNT ||
               a == cdt_pkg::OFS_CONTROL || a == cdt_pkg::OFS_STATUS;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
                v[i*8 +: 8] = nw[i*8 +: 8];
        end
        return v;
    endfunction

    // ==========================================
    // Next state
    always_comb
    begin
        logic [31:0] cur;
        logic [31:0] nw;
        logic [cdt_pkg::EVC_W-1:0] target;
        logic [cdt_pkg::EVC_W-1:0] next_sets;
        cur = 32'h0;
        nw = 32'h0;
        target = '0;
        next_sets = '0;
        s_d = s_q;

        // Write channel: address and data taken in either order
        if (s_q.awready && s_axi_awvalid)
        begin
            s_d.awaddr = s_axi_awaddr;
            s_d.aw_have = 1'b1;
        end
        if (s_q.wready && s_axi_wvalid)
        begin
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
            s_d.w_have = 1'b1;
        end
        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
        begin
            cur = read_word(s_q, s_q.awaddr, {red_blk, blue_blk, luma_blk});
            nw = merge(cur, s_q.wdata, s_q.wstrb);
            case (s_q.awaddr)
                cdt_pkg::OFS_THRESHOLD:
                begin
                    // Only the defined fields are stored
                    s_d.field2_dword_threshold = nw[cdt_pkg::THR2_LSB +: cdt_pkg::THR_W];
                    s_d.field1_dword_threshold = nw[cdt_pkg::THR1_LSB +: cdt_pkg::THR_W];
                end
                cdt_pkg::OFS_EVENT_COUNT:
                begin
                    s_d.field2_event_sets = nw[cdt_pkg::EVC2_LSB +: cdt_pkg::EVC_W];
                    s_d.field1_event_sets = nw[cdt_pkg::EVC1_LSB +: cdt_pkg::EVC_W];
                end
                cdt_pkg::OFS_CONTROL:
                begin
                    s_d.mode = nw[cdt_pkg::CTL_MODE_LSB +: 2];
                    s_d.size = nw[cdt_pkg::CTL_SIZE_LSB +: 3];
                    s_d.field2_threshold_enable = nw[cdt_pkg::CTL_F2EN_BIT];
                end
                default:
                begin
                end
            endcase
            s_d.bresp = mapped(s_q.awaddr) ? cdt_pkg::RESP_OKAY : cdt_pkg::RESP_SLVERR;
            s_d.bvalid = 1'b1;
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;

        // Read channel: one outstanding read, answered the cycle after
        if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;
        if (s_q.arready && s_axi_arvalid)
        begin
            s_d.rdata = read_word(s_q, s_axi_araddr, {red_blk, blue_blk, luma_blk});
            s_d.rresp = mapped(s_axi_araddr) ? cdt_pkg::RESP_OKAY : cdt_pkg::RESP_SLVERR;
            s_d.rvalid = 1'b1;
        end
        s_d.arready = !s_d.rvalid;

        // Event set counting and threshold switching
        target = s_q.use_field2 ? s_q.field2_event_sets : s_q.field1_event_sets;
        next_sets = s_q.sets_done + 1'b1;
        if (field_start)
        begin
            s_d.sets_done = '0;
            s_d.use_field2 = field_is_two && s_q.field2_threshold_enable;
        end
        else if (luma_evt && component)
        begin
            // A zero count never switches; counts are unused outside component modes
            if (target != '0 && next_sets == target)
            begin
                s_d.sets_done = '0;
                s_d.use_field2 = !s_q.use_field2 && s_q.field2_threshold_enable;
            end
            else
                s_d.sets_done = next_sets;
        end
        s_d.thr_out = luma_thr;

        // Channel reset returns registers and counters to reset values
        if (channel_reset)
        begin
            s_d.field1_dword_threshold = '0;
            s_d.field2_dword_threshold = '0;
            s_d.field1_event_sets = '0;
            s_d.field2_event_sets = '0;
            s_d.mode = 2'h0;
            s_d.size = 3'h0;
            s_d.field2_threshold_enable = 1'b0;
            s_d.sets_done = '0;
            s_d.use_field2 = 1'b0;
            // The registered threshold would otherwise show the old value for a cycle
            s_d.thr_out = '0;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign luma_dma_event = luma_evt;
    assign blue_chroma_dma_event = blue_evt;
    assign red_chroma_dma_event = red_evt;
    assign active_threshold = s_q.thr_out;
    assign active_field_two = s_q.use_field2;
endmodule

// *** dv/cdt_dma_model.sv ***
// DMA controller model: reads each FIFO once for every event it sees.
// Assumes event pulses on aclk; stall holds every read back.
module cdt_dma_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall,
    input wire logic [2:0] dma_event,
    output logic [2:0] dma_read
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] pend_q;
    // ==========
    // Service: a stalled read is owed until the stall lifts
    always_ff @(posedge aclk)
    begin
        dma_read <= 3'h0;
        if (!aresetn)
            pend_q <= 3'h0;
        else if (stall)
            pend_q <= pend_q | dma_event;
        else
        begin
            dma_read <= pend_q | dma_event;
            pend_q <= 3'h0;
        end
    end
endmodule

// *** dv/cdt_capture_dma_sva.sv ***
// Port assertions for the capture DMA event block.
// Assumes one clock and a bus master holding bready and rready high.
module cdt_capture_dma_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic channel_reset,
    input wire logic field_start,
    input wire logic field_is_two,
    input wire logic luma_dma_read,
    input wire logic luma_dma_event,
    input wire logic [cdt_pkg::THR_W-1:0] active_threshold,
    input wire logic active_field_two
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic hold_q;
    logic hold_d;
    // ==========
    // Helper: an event is owed one read before the next
    always_comb hold_d = (hold_q | luma_dma_event) & ~luma_dma_read;
    always_ff @(posedge aclk)
        hold_q <= (!aresetn || channel_reset || field_start) ? 1'b0 : hold_d;
    // ==========
    // Register bus
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_write_answer;
        ##2 s_axi_bvalid;
    endsequence
    chk_write_answer: assert property (s_write_taken |-> s_write_answer)
        else $error("write response not two cycles after the write");
    chk_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1] s_axi_awready)
        else $error("write channel not reopened after response");
    chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 !s_axi_rvalid)
        else $error("read data not one cycle after address");
    chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    chk_reset_quiet: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready && !luma_dma_event)
        else $error("outputs active after reset");
    // ==========
    // Events and threshold selection
    chk_event_held: assert property (luma_dma_event |-> !hold_q)
        else $error("event raised before the previous one was read");
    chk_chan_clear: assert property (channel_reset |=> active_threshold == '0 && !active_field_two)
        else $error("channel reset left a threshold in force");
    chk_field_one: assert property (field_start && !field_is_two |=> !active_field_two)
        else $error("field one start chose the field two threshold");
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the capture DMA event block.
// Assumes package, design, DMA model and checker compiled before it.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] mode; logic [2:0] size; logic [9:0] thr; logic [3:0] spd;} cdt_row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic channel_reset, field_start, field_is_two, luma_wr_value, blue_wr_value, red_wr_value, stall;
    logic luma_dma_event, blue_chroma_dma_event, red_chroma_dma_event, active_field_two;
    logic [cdt_pkg::THR_W-1:0] active_threshold;
    logic [2:0] dma_rd;
    wire luma_dma_read = dma_rd[0];
    wire blue_dma_read = dma_rd[1];
    wire red_dma_read = dma_rd[2];
    int failures, total_checks, ev_l, ev_b, ev_r;
    // Mode, size, threshold, values per double word
    cdt_row_t rows [10] = '{
        '{2'h0, 3'h0, 10'h002, 4'h8},
        '{2'h0, 3'h1, 10'h002, 4'h4},
        '{2'h0, 3'h2, 10'h002, 4'h6},
        '{2'h1, 3'h0, 10'h003, 4'h8},
        '{2'h1, 3'h1, 10'h003, 4'h4},
        '{2'h1, 3'h2, 10'h001, 4'h6},
        '{2'h1, 3'h3, 10'h002, 4'h4},
        '{2'h1, 3'h4, 10'h005, 4'h2},
        '{2'h1, 3'h4, 10'h3ff, 4'h2},
        '{2'h2, 3'h4, 10'h002, 4'h8}};
    cdt_capture_dma dut (.*);
    cdt_dma_model dma (.aclk(aclk), .aresetn(aresetn), .stall(stall),
        .dma_event({red_chroma_dma_event, blue_chroma_dma_event, luma_dma_event}), .dma_read(dma_rd));
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        ev_l <= ev_l + int'(luma_dma_event === 1'b1);
        ev_b <= ev_b + int'(blue_chroma_dma_event === 1'b1);
        ev_r <= ev_r + int'(red_chroma_dma_event === 1'b1);
    end
    // ==========
    // Shared tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        check("write response", 32'h0, 32'(s_axi_bresp));
    endtask
    task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        check(what, exp, s_axi_rdata);
        check({what, " resp"}, 32'h0, 32'(s_axi_rresp));
    endtask
    task automatic new_field(input logic two);
        field_is_two <= two;
        field_start <= 1'b1;
        @(posedge aclk);
        field_start <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic push(input int n, input logic [2:0] which);
        repeat (n)
        begin
            {red_wr_value, blue_wr_value, luma_wr_value} <= which;
            @(posedge aclk);
        end
        {red_wr_value, blue_wr_value, luma_wr_value} <= 3'h0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic see(input string what, input logic [9:0] thr, input logic two);
        check({what, " threshold"}, 32'(thr), 32'(active_threshold));
        check({what, " field"}, 32'(two), 32'(active_field_two));
    endtask
    // ==========
    // Main sequence
    initial
    begin
        int need;
        int b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, channel_reset, field_start, field_is_two} = 6'h00;
        {luma_wr_value, blue_wr_value, red_wr_value, stall} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdchk("threshold reset", cdt_pkg::OFS_THRESHOLD, 32'h0);
        rdchk("event count reset", cdt_pkg::OFS_EVENT_COUNT, 32'h0);
        wr(cdt_pkg::OFS_THRESHOLD, 32'hffff_ffff);
        wr(cdt_pkg::OFS_EVENT_COUNT, 32'hffff_ffff);
        rdchk("threshold fields", cdt_pkg::OFS_THRESHOLD, 32'h03ff_03ff);
        rdchk("event count fields", cdt_pkg::OFS_EVENT_COUNT, 32'h0fff_0fff);
        channel_reset <= 1'b1;
        @(posedge aclk);
        channel_reset <= 1'b0;
        @(posedge aclk);
        rdchk("threshold cleared", cdt_pkg::OFS_THRESHOLD, 32'h0);
        rdchk("event count cleared", cdt_pkg::OFS_EVENT_COUNT, 32'h0);
        $display("test registers done");
        foreach (rows[i])
        begin
            need = int'(rows[i].spd) * int'(rows[i].thr);
            stall <= 1'b1;
            wr(cdt_pkg::OFS_CONTROL, 32'({rows[i].size, rows[i].mode}) | 32'h100);
            wr(cdt_pkg::OFS_THRESHOLD, 32'h0001_0000 | 32'(rows[i].thr));
            wr(cdt_pkg::OFS_EVENT_COUNT, rows[i].mode != 2'h0 ? 32'h0001_0001 : 32'h0);
            new_field(rows[i].mode != 2'h0);
            see("mode row", rows[i].thr, rows[i].mode != 2'h0);
            b0 = ev_l;
            push(need - 1, 3'h1);
            check("event before threshold", b0, ev_l);
            push(1, 3'h1);
            check("event at threshold", b0 + 1, ev_l);
            push(need, 3'h1);
            check("event while unread", b0 + 1, ev_l);
            stall <= 1'b0;
            repeat (4) @(posedge aclk);
            check("event after read", b0 + 2, ev_l);
        end
        $display("test threshold rows done");
        stall <= 1'b1;
        wr(cdt_pkg::OFS_CONTROL, 32'h0);
        wr(cdt_pkg::OFS_THRESHOLD, 32'h0000_0004);
        new_field(1'b0);
        b0 = ev_l;
        push(16, 3'h7);
        check("luma below threshold", b0, ev_l);
        push(16, 3'h1);
        check("luma at threshold", b0 + 1, ev_l);
        check("blue at half threshold", 32'h1, ev_b);
        check("red at half threshold", 32'h1, ev_r);
        stall <= 1'b0;
        wr(cdt_pkg::OFS_CONTROL, 32'h1);
        new_field(1'b0);
        push(32, 3'h6);
        check("chroma in raw mode", 32'h1, ev_b);
        $display("test chroma done");
        wr(cdt_pkg::OFS_CONTROL, 32'h0000_0100);
        wr(cdt_pkg::OFS_THRESHOLD, 32'h0002_0001);
        wr(cdt_pkg::OFS_EVENT_COUNT, 32'h0001_0002);
        new_field(1'b0);
        see("field one", 10'h001, 1'b0);
        b0 = ev_l;
        push(16, 3'h1);
        see("after field one sets", 10'h002, 1'b1);
        push(16, 3'h1);
        see("after field two sets", 10'h001, 1'b0);
        check("event sets", b0 + 3, ev_l);
        wr(cdt_pkg::OFS_CONTROL, 32'h0);
        new_field(1'b1);
        see("field two disabled", 10'h001, 1'b0);
        wr(cdt_pkg::OFS_CONTROL, 32'h0000_0100);
        new_field(1'b1);
        see("field two enabled", 10'h002, 1'b1);
        $display("test event sets done");
        results();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        failures++;
        $display("[FAIL] watchdog expected finish seen timeout");
        results();
    end
endmodule
bind cdt_capture_dma cdt_capture_dma_sva chk (.*);
